// ===== src/pmicia_top.sv
// two-level interrupt aggregator: event latches, masks, live views,
// first-level summary and the active-low request pin.
// assumes event pulses and live levels are synchronous to SYS_CLK and the
// register request comes from a serial front end, one strobe per access.
//
// Notes on behaviour
// - unmasked set latch holds request pin low
// - live bits show present trigger signal state
// - request pin is OR of enabled latches
// - summary names group, second level names source
// - summary bit 0 from general latch group
// - summary bit 1 from second status group
// - summary bit 2 from buck mode group
// - summary bit 3 from buck/linear current limit
// - summary bit 4 from buck/linear undervoltage
// - summary bit 5 from buck/linear overvoltage
// - summary bit 6 from power button group
// - summary bit 7 on early warning event
// - masked latches never set summary bits
// - summary bits 0-6 clear themselves with their latches; bit 7 clears by a write of one
// - pin held until all unmasked latches clear
// - thermal thresholds bits 0-5, sync 6, watchdog 7
// - buck registers use bits 0-6, bit 7 unused; buck mode live register has no bits and reads zero
// - linear registers use bits 0-3 only
// - button press, release, held, bandgap bit layout
// - event sets latch, write one clears it
// - mask one removes latch from request pin
// - bypassed faults still latch and request

`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////

module pmicia_event_group #(
  parameter logic [7:0] VALID = 8'hFF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] evt,
  input  wire logic       clr_we,
  input  wire logic       mask_we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] latch,
  output logic      [7:0] mask,
  output logic            pend
);

  // bypass never reaches here, so bypassed faults still latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch <= pmicia_pkg::LATCH_RESET;
    end else begin
      latch <= ((latch & ~(clr_we ? wdata : 8'h00)) | evt) & VALID;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask <= pmicia_pkg::MASK_RESET & VALID;
    end else if (mask_we) begin
      mask <= wdata & VALID;
    end
  end

  assign pend = |(latch & ~mask);

endmodule // pmicia_event_group

////////////////////////////////////////////////////////////////////////////////

module pmicia_top (
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST,
  input  wire pmicia_pkg::pmicia_reg_req_t   REG_REQ,
  output logic      [7:0]                    REG_RDATA,
  output logic                               REG_RVALID,
  input  wire pmicia_pkg::pmicia_grp_bytes_t EVENT_PULSE,
  input  wire pmicia_pkg::pmicia_grp_bytes_t LIVE_STATE,
  input  wire logic                          EARLY_WARNING_EVENT,
  output logic                               IRQ_REQUEST_PIN_N,
  output logic                               IRQ_REQUEST_PIN_OE
);

  pmicia_pkg::pmicia_grp_bytes_t latch;
  pmicia_pkg::pmicia_grp_bytes_t mask;
  logic [pmicia_pkg::NGRP-1:0]   pend;
  logic [7:0]                    top_level_summary;
  logic                          early_warning_flag;
  logic [7:0]                    next_rdata;
  logic                          sum_clr_ew;
  pmicia_pkg::pmicia_grp_bytes_t live;
  logic [pmicia_pkg::NGRP-1:0]   clr_we;
  logic [pmicia_pkg::NGRP-1:0]   mask_we;

  // latch at each group base, mask and live follow it
  localparam logic [4:0] BASE_GENERAL     = 5'(pmicia_pkg::GRP_GENERAL * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_THERMAL     = 5'(pmicia_pkg::GRP_THERMAL * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_BUCK_MODE   = 5'(pmicia_pkg::GRP_BUCK_MODE * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_BUCK_ILIM   = 5'(pmicia_pkg::GRP_BUCK_ILIM * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_LINEAR_ILIM = 5'(pmicia_pkg::GRP_LINEAR_ILIM * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_BUCK_UV     = 5'(pmicia_pkg::GRP_BUCK_UV * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_LINEAR_UV   = 5'(pmicia_pkg::GRP_LINEAR_UV * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_BUCK_OV     = 5'(pmicia_pkg::GRP_BUCK_OV * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_LINEAR_OV   = 5'(pmicia_pkg::GRP_LINEAR_OV * pmicia_pkg::REG_STRIDE);
  localparam logic [4:0] BASE_BUTTON      = 5'(pmicia_pkg::GRP_BUTTON * pmicia_pkg::REG_STRIDE);

  //////////////////////////////////////////////////////////////////////////////
  // second level: one latch/mask pair per group, layouts fixed by VALID

  // one-hot strobes, so one access never touches two registers
  always_comb begin
    clr_we  = '0;
    mask_we = '0;
    for (int g = 0; g < pmicia_pkg::NGRP; g++) begin
      clr_we[g]  = REG_REQ.wr && REG_REQ.addr == 5'(g * pmicia_pkg::REG_STRIDE);
      mask_we[g] = REG_REQ.wr && REG_REQ.addr == 5'(g * pmicia_pkg::REG_STRIDE + pmicia_pkg::REG_MASK_OFS);
    end
  end

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_GENERAL])
  ) u_general (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_GENERAL]),
    .clr_we  (clr_we[pmicia_pkg::GRP_GENERAL]),
    .mask_we (mask_we[pmicia_pkg::GRP_GENERAL]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_GENERAL]),
    .mask    (mask[pmicia_pkg::GRP_GENERAL]),
    .pend    (pend[pmicia_pkg::GRP_GENERAL])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_THERMAL])
  ) u_thermal (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_THERMAL]),
    .clr_we  (clr_we[pmicia_pkg::GRP_THERMAL]),
    .mask_we (mask_we[pmicia_pkg::GRP_THERMAL]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_THERMAL]),
    .mask    (mask[pmicia_pkg::GRP_THERMAL]),
    .pend    (pend[pmicia_pkg::GRP_THERMAL])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_BUCK_MODE])
  ) u_buck_mode (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_BUCK_MODE]),
    .clr_we  (clr_we[pmicia_pkg::GRP_BUCK_MODE]),
    .mask_we (mask_we[pmicia_pkg::GRP_BUCK_MODE]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_BUCK_MODE]),
    .mask    (mask[pmicia_pkg::GRP_BUCK_MODE]),
    .pend    (pend[pmicia_pkg::GRP_BUCK_MODE])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_BUCK_ILIM])
  ) u_buck_ilim (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_BUCK_ILIM]),
    .clr_we  (clr_we[pmicia_pkg::GRP_BUCK_ILIM]),
    .mask_we (mask_we[pmicia_pkg::GRP_BUCK_ILIM]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_BUCK_ILIM]),
    .mask    (mask[pmicia_pkg::GRP_BUCK_ILIM]),
    .pend    (pend[pmicia_pkg::GRP_BUCK_ILIM])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_LINEAR_ILIM])
  ) u_linear_ilim (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_LINEAR_ILIM]),
    .clr_we  (clr_we[pmicia_pkg::GRP_LINEAR_ILIM]),
    .mask_we (mask_we[pmicia_pkg::GRP_LINEAR_ILIM]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_LINEAR_ILIM]),
    .mask    (mask[pmicia_pkg::GRP_LINEAR_ILIM]),
    .pend    (pend[pmicia_pkg::GRP_LINEAR_ILIM])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_BUCK_UV])
  ) u_buck_uv (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_BUCK_UV]),
    .clr_we  (clr_we[pmicia_pkg::GRP_BUCK_UV]),
    .mask_we (mask_we[pmicia_pkg::GRP_BUCK_UV]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_BUCK_UV]),
    .mask    (mask[pmicia_pkg::GRP_BUCK_UV]),
    .pend    (pend[pmicia_pkg::GRP_BUCK_UV])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_LINEAR_UV])
  ) u_linear_uv (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_LINEAR_UV]),
    .clr_we  (clr_we[pmicia_pkg::GRP_LINEAR_UV]),
    .mask_we (mask_we[pmicia_pkg::GRP_LINEAR_UV]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_LINEAR_UV]),
    .mask    (mask[pmicia_pkg::GRP_LINEAR_UV]),
    .pend    (pend[pmicia_pkg::GRP_LINEAR_UV])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_BUCK_OV])
  ) u_buck_ov (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_BUCK_OV]),
    .clr_we  (clr_we[pmicia_pkg::GRP_BUCK_OV]),
    .mask_we (mask_we[pmicia_pkg::GRP_BUCK_OV]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_BUCK_OV]),
    .mask    (mask[pmicia_pkg::GRP_BUCK_OV]),
    .pend    (pend[pmicia_pkg::GRP_BUCK_OV])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_LINEAR_OV])
  ) u_linear_ov (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_LINEAR_OV]),
    .clr_we  (clr_we[pmicia_pkg::GRP_LINEAR_OV]),
    .mask_we (mask_we[pmicia_pkg::GRP_LINEAR_OV]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_LINEAR_OV]),
    .mask    (mask[pmicia_pkg::GRP_LINEAR_OV]),
    .pend    (pend[pmicia_pkg::GRP_LINEAR_OV])
  );

  pmicia_event_group #(
    .VALID (pmicia_pkg::LATCH_VALID[pmicia_pkg::GRP_BUTTON])
  ) u_button (
    .clk     (SYS_CLK),
    .rst     (RST),
    .evt     (EVENT_PULSE[pmicia_pkg::GRP_BUTTON]),
    .clr_we  (clr_we[pmicia_pkg::GRP_BUTTON]),
    .mask_we (mask_we[pmicia_pkg::GRP_BUTTON]),
    .wdata   (REG_REQ.wdata),
    .latch   (latch[pmicia_pkg::GRP_BUTTON]),
    .mask    (mask[pmicia_pkg::GRP_BUTTON]),
    .pend    (pend[pmicia_pkg::GRP_BUTTON])
  );

  //////////////////////////////////////////////////////////////////////////////
  // early warning has no second level; clears by writing one to its summary bit

  assign sum_clr_ew = REG_REQ.wr && REG_REQ.addr == pmicia_pkg::REG_TOP_SUMMARY
                      && REG_REQ.wdata[pmicia_pkg::SUM_EARLY_WARN];

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      early_warning_flag <= 1'b0;
    end else begin
      early_warning_flag <= EARLY_WARNING_EVENT | (early_warning_flag & ~sum_clr_ew);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // first level: pure function of pending groups and the early warning flag; group bits clear with their groups

  always_comb begin
    top_level_summary = 8'h00;
    top_level_summary[pmicia_pkg::SUM_GENERAL] = pend[pmicia_pkg::GRP_GENERAL];
    top_level_summary[pmicia_pkg::SUM_SECOND]  = pend[pmicia_pkg::GRP_THERMAL];
    top_level_summary[pmicia_pkg::SUM_MODE]    = pend[pmicia_pkg::GRP_BUCK_MODE];
    top_level_summary[pmicia_pkg::SUM_CURRENT_LIM] = pend[pmicia_pkg::GRP_BUCK_ILIM]
                                                   | pend[pmicia_pkg::GRP_LINEAR_ILIM];
    top_level_summary[pmicia_pkg::SUM_UNDERVOLT]   = pend[pmicia_pkg::GRP_BUCK_UV]
                                                   | pend[pmicia_pkg::GRP_LINEAR_UV];
    top_level_summary[pmicia_pkg::SUM_OVERVOLT]    = pend[pmicia_pkg::GRP_BUCK_OV]
                                                   | pend[pmicia_pkg::GRP_LINEAR_OV];
    top_level_summary[pmicia_pkg::SUM_BUTTON]      = pend[pmicia_pkg::GRP_BUTTON];
    top_level_summary[pmicia_pkg::SUM_EARLY_WARN]  = early_warning_flag;
  end

  //////////////////////////////////////////////////////////////////////////////
  // request pin: open-drain, only ever pulled low, registered against glitches

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IRQ_REQUEST_PIN_N <= 1'b1;
    end else begin
      IRQ_REQUEST_PIN_N <= ~(|top_level_summary);
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      IRQ_REQUEST_PIN_OE <= 1'b0;
    end else begin
      IRQ_REQUEST_PIN_OE <= |top_level_summary;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read: unmapped and unused positions return zero

  assign live = LIVE_STATE & pmicia_pkg::LIVE_VALID;

  // live reads pass straight through; no history is kept
  always_comb begin
    next_rdata = 8'h00;
    case (REG_REQ.addr)
      BASE_GENERAL:                                     next_rdata = latch[pmicia_pkg::GRP_GENERAL];
      5'(BASE_GENERAL + pmicia_pkg::REG_MASK_OFS):      next_rdata = mask[pmicia_pkg::GRP_GENERAL];
      5'(BASE_GENERAL + pmicia_pkg::REG_LIVE_OFS):      next_rdata = live[pmicia_pkg::GRP_GENERAL];
      BASE_THERMAL:                                     next_rdata = latch[pmicia_pkg::GRP_THERMAL];
      5'(BASE_THERMAL + pmicia_pkg::REG_MASK_OFS):      next_rdata = mask[pmicia_pkg::GRP_THERMAL];
      5'(BASE_THERMAL + pmicia_pkg::REG_LIVE_OFS):      next_rdata = live[pmicia_pkg::GRP_THERMAL];
      BASE_BUCK_MODE:                                   next_rdata = latch[pmicia_pkg::GRP_BUCK_MODE];
      5'(BASE_BUCK_MODE + pmicia_pkg::REG_MASK_OFS):    next_rdata = mask[pmicia_pkg::GRP_BUCK_MODE];
      5'(BASE_BUCK_MODE + pmicia_pkg::REG_LIVE_OFS):    next_rdata = live[pmicia_pkg::GRP_BUCK_MODE];
      BASE_BUCK_ILIM:                                   next_rdata = latch[pmicia_pkg::GRP_BUCK_ILIM];
      5'(BASE_BUCK_ILIM + pmicia_pkg::REG_MASK_OFS):    next_rdata = mask[pmicia_pkg::GRP_BUCK_ILIM];
      5'(BASE_BUCK_ILIM + pmicia_pkg::REG_LIVE_OFS):    next_rdata = live[pmicia_pkg::GRP_BUCK_ILIM];
      BASE_LINEAR_ILIM:                                 next_rdata = latch[pmicia_pkg::GRP_LINEAR_ILIM];
      5'(BASE_LINEAR_ILIM + pmicia_pkg::REG_MASK_OFS):  next_rdata = mask[pmicia_pkg::GRP_LINEAR_ILIM];
      5'(BASE_LINEAR_ILIM + pmicia_pkg::REG_LIVE_OFS):  next_rdata = live[pmicia_pkg::GRP_LINEAR_ILIM];
      BASE_BUCK_UV:                                     next_rdata = latch[pmicia_pkg::GRP_BUCK_UV];
      5'(BASE_BUCK_UV + pmicia_pkg::REG_MASK_OFS):      next_rdata = mask[pmicia_pkg::GRP_BUCK_UV];
      5'(BASE_BUCK_UV + pmicia_pkg::REG_LIVE_OFS):      next_rdata = live[pmicia_pkg::GRP_BUCK_UV];
      BASE_LINEAR_UV:                                   next_rdata = latch[pmicia_pkg::GRP_LINEAR_UV];
      5'(BASE_LINEAR_UV + pmicia_pkg::REG_MASK_OFS):    next_rdata = mask[pmicia_pkg::GRP_LINEAR_UV];
      5'(BASE_LINEAR_UV + pmicia_pkg::REG_LIVE_OFS):    next_rdata = live[pmicia_pkg::GRP_LINEAR_UV];
      BASE_BUCK_OV:                                     next_rdata = latch[pmicia_pkg::GRP_BUCK_OV];
      5'(BASE_BUCK_OV + pmicia_pkg::REG_MASK_OFS):      next_rdata = mask[pmicia_pkg::GRP_BUCK_OV];
      5'(BASE_BUCK_OV + pmicia_pkg::REG_LIVE_OFS):      next_rdata = live[pmicia_pkg::GRP_BUCK_OV];
      BASE_LINEAR_OV:                                   next_rdata = latch[pmicia_pkg::GRP_LINEAR_OV];
      5'(BASE_LINEAR_OV + pmicia_pkg::REG_MASK_OFS):    next_rdata = mask[pmicia_pkg::GRP_LINEAR_OV];
      5'(BASE_LINEAR_OV + pmicia_pkg::REG_LIVE_OFS):    next_rdata = live[pmicia_pkg::GRP_LINEAR_OV];
      BASE_BUTTON:                                      next_rdata = latch[pmicia_pkg::GRP_BUTTON];
      5'(BASE_BUTTON + pmicia_pkg::REG_MASK_OFS):       next_rdata = mask[pmicia_pkg::GRP_BUTTON];
      5'(BASE_BUTTON + pmicia_pkg::REG_LIVE_OFS):       next_rdata = live[pmicia_pkg::GRP_BUTTON];
      pmicia_pkg::REG_TOP_SUMMARY:                      next_rdata = top_level_summary;
      default:                                          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (REG_REQ.rd) begin
      REG_RDATA <= next_rdata;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
    end
  end

endmodule // pmicia_top

`default_nettype wire

// ===== src/pmicia_pkg.sv
// package for the two-level interrupt aggregator: register map, group layout,
// reset values and the carrier types shared by the design and its bench.
// assumes a host-side serial register front end that turns frames into
// single-cycle read and write strobes on the register request struct.
package pmicia_pkg;

  localparam int NGRP = 10;

  // group order inside the packed carriers
  localparam int GRP_GENERAL     = 0;
  localparam int GRP_THERMAL     = 1;
  localparam int GRP_BUCK_MODE   = 2;
  localparam int GRP_BUCK_ILIM   = 3;
  localparam int GRP_LINEAR_ILIM = 4;
  localparam int GRP_BUCK_UV     = 5;
  localparam int GRP_LINEAR_UV   = 6;
  localparam int GRP_BUCK_OV     = 7;
  localparam int GRP_LINEAR_OV   = 8;
  localparam int GRP_BUTTON      = 9;

  // each group holds latch, mask, live at base, base+1, base+2
  localparam int REG_STRIDE      = 3;
  localparam int REG_MASK_OFS    = 1;
  localparam int REG_LIVE_OFS    = 2;
  localparam logic [4:0] REG_TOP_SUMMARY = 5'h1E;

  // implemented bit positions per group
  localparam logic [NGRP-1:0][7:0] LATCH_VALID = {
    8'hFF, 8'h0F, 8'h7F, 8'h0F, 8'h7F, 8'h0F, 8'h7F, 8'h7F, 8'hFF, 8'hFF
  };
  localparam logic [NGRP-1:0][7:0] LIVE_VALID = {
    8'h81, 8'h0F, 8'h7F, 8'h0F, 8'h7F, 8'h0F, 8'h7F, 8'h00, 8'hFF, 8'h07
  };

  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'hFF;

  // summary bit positions
  localparam int SUM_GENERAL     = 0;
  localparam int SUM_SECOND      = 1;
  localparam int SUM_MODE        = 2;
  localparam int SUM_CURRENT_LIM = 3;
  localparam int SUM_UNDERVOLT   = 4;
  localparam int SUM_OVERVOLT    = 5;
  localparam int SUM_BUTTON      = 6;
  localparam int SUM_EARLY_WARN  = 7;

  typedef logic [NGRP-1:0][7:0] pmicia_grp_bytes_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } pmicia_reg_req_t;

endpackage : pmicia_pkg

// ===== tb/pmicia_chk_checker.sv
// checker: port-level relations of the interrupt aggregator
// assumes bind onto pmicia_top, one clock, async active-high reset
`timescale 1ns/1ps
`default_nettype none
module pmicia_chk (
  input wire logic                          SYS_CLK,
  input wire logic                          RST,
  input wire pmicia_pkg::pmicia_reg_req_t   REG_REQ,
  input wire logic [7:0]                    REG_RDATA,
  input wire logic                          REG_RVALID,
  input wire pmicia_pkg::pmicia_grp_bytes_t EVENT_PULSE,
  input wire pmicia_pkg::pmicia_grp_bytes_t LIVE_STATE,
  input wire logic                          EARLY_WARNING_EVENT,
  input wire logic                          IRQ_REQUEST_PIN_N,
  input wire logic                          IRQ_REQUEST_PIN_OE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  property p_oe; IRQ_REQUEST_PIN_OE == !IRQ_REQUEST_PIN_N; endproperty
  a_oe: assert property (p_oe) else $error("pin enable off level");
  property p_rv; REG_RVALID == $past(REG_REQ.rd); endproperty
  a_rv: assert property (p_rv) else $error("read valid late");
  property p_ew; EARLY_WARNING_EVENT |-> ##2 !IRQ_REQUEST_PIN_N; endproperty
  a_ew: assert property (p_ew) else $error("warning not on pin");
  // release needs a clearing or masking write two edges back
  property p_rel; $rose(IRQ_REQUEST_PIN_N) |-> $past(REG_REQ.wr, 2); endproperty
  a_rel: assert property (p_rel) else $error("pin released alone");
  property p_unm; REG_REQ.rd && REG_REQ.addr == 5'h1F |=> REG_RDATA == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_th; REG_REQ.rd && REG_REQ.addr == 5'h05 |=> REG_RDATA == $past(LIVE_STATE[1]); endproperty
  a_th: assert property (p_th) else $error("thermal live wrong");
  property p_bk; REG_REQ.rd && REG_REQ.addr == 5'h0B |=> REG_RDATA == ($past(LIVE_STATE[3]) & 8'h7F); endproperty
  a_bk: assert property (p_bk) else $error("buck live wrong");
  property p_ln; REG_REQ.rd && REG_REQ.addr == 5'h0E |=> REG_RDATA == ($past(LIVE_STATE[4]) & 8'h0F); endproperty
  a_ln: assert property (p_ln) else $error("linear live wrong");
  property p_bt; REG_REQ.rd && REG_REQ.addr == 5'h1D |=> REG_RDATA == ($past(LIVE_STATE[9]) & 8'h81); endproperty
  a_bt: assert property (p_bt) else $error("button live wrong");
endmodule // pmicia_chk
bind pmicia_top pmicia_chk pmicia_chk_i (.SYS_CLK, .RST, .REG_REQ, .REG_RDATA, .REG_RVALID, .EVENT_PULSE,
  .LIVE_STATE, .EARLY_WARNING_EVENT, .IRQ_REQUEST_PIN_N, .IRQ_REQUEST_PIN_OE);
`default_nettype wire

// ===== tb/pmicia_host.sv
// host model: one register access at a time
// assumes one-cycle strobes taken at the next rising edge
`timescale 1ns/1ps
`default_nettype none
module pmicia_host (
  input  wire logic                      SYS_CLK,
  output var pmicia_pkg::pmicia_reg_req_t REG_REQ,
  input  wire logic [7:0]                REG_RDATA,
  input  wire logic                      REG_RVALID
);
  initial REG_REQ = '0;
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge SYS_CLK) REG_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge SYS_CLK) REG_REQ <= '0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
    @(posedge SYS_CLK) REG_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge SYS_CLK) REG_REQ <= '0;
    // sample after the answer edge settles
    #1 d = REG_RDATA;
    v = REG_RVALID;
  endtask
endmodule // pmicia_host
`default_nettype wire

// ===== tb/tb.sv
// testbench: random and corner event traffic per group
// assumes design, checker bind and host model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [4:0] sum_a = pmicia_pkg::REG_TOP_SUMMARY;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  pmicia_pkg::pmicia_reg_req_t REG_REQ;
  logic [7:0] REG_RDATA;
  logic REG_RVALID;
  pmicia_pkg::pmicia_grp_bytes_t EVENT_PULSE = '0;
  pmicia_pkg::pmicia_grp_bytes_t LIVE_STATE = '0;
  logic EARLY_WARNING_EVENT = 1'b0;
  logic IRQ_REQUEST_PIN_N;
  logic IRQ_REQUEST_PIN_OE;
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'd71336;
  logic [7:0] d, p;
  logic v;
  always #2 SYS_CLK = ~SYS_CLK;
  pmicia_top pmicia_top_i (.SYS_CLK, .RST, .REG_REQ, .REG_RDATA, .REG_RVALID, .EVENT_PULSE, .LIVE_STATE,
    .EARLY_WARNING_EVENT, .IRQ_REQUEST_PIN_N, .IRQ_REQUEST_PIN_OE);
  pmicia_host pmicia_host_i (.SYS_CLK, .REG_REQ, .REG_RDATA, .REG_RVALID);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // buck and linear pairs share one summary bit
  function automatic int sum_bit(input int g);
    return g < 3 ? g : g == 9 ? 6 : (g - 1) / 2 + 2;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
    pmicia_host_i.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  task automatic ev(input int g, input logic [7:0] x);
    @(posedge SYS_CLK) EVENT_PULSE[g] <= x;
    @(posedge SYS_CLK) EVENT_PULSE <= '0;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    for (int g = 0; g < 10; g++) begin
      rdc(5'(3 * g), 8'h00);
      rdc(5'(3 * g + 1), pmicia_pkg::MASK_RESET & pmicia_pkg::LATCH_VALID[g]);
    end
    rdc(sum_a, 8'h00);
    $display("done reset values");
    for (int g = 0; g < 10; g++) begin
      seed = lfsr(seed);
      p = (seed[7:0] | 8'h01) & pmicia_pkg::LATCH_VALID[g];
      @(posedge SYS_CLK) LIVE_STATE[g] <= seed[15:8];
      pmicia_host_i.wr(5'(3 * g + 1), 8'h00);
      ev(g, seed[7:0] | 8'h01);
      rdc(5'(3 * g), p);
      rdc(sum_a, 8'h01 << sum_bit(g));
      chk({6'h00, IRQ_REQUEST_PIN_OE, IRQ_REQUEST_PIN_N}, 8'h02);
      rdc(5'(3 * g + 2), seed[15:8] & pmicia_pkg::LIVE_VALID[g]);
      pmicia_host_i.wr(5'(3 * g), p);
      rdc(sum_a, 8'h00);
      chk({6'h00, IRQ_REQUEST_PIN_OE, IRQ_REQUEST_PIN_N}, 8'h01);
      pmicia_host_i.wr(5'(3 * g + 1), 8'hFF);
      ev(g, p);
      rdc(5'(3 * g), p);
      rdc(sum_a, 8'h00);
      chk({6'h00, IRQ_REQUEST_PIN_OE, IRQ_REQUEST_PIN_N}, 8'h01);
      // clear and new event on the same edge
      fork
        pmicia_host_i.wr(5'(3 * g), p);
        ev(g, p);
      join
      rdc(5'(3 * g), p);
      pmicia_host_i.wr(5'(3 * g), p);
      $display("done group %0d", g);
    end
    // two groups pending: pin waits for the last one
    pmicia_host_i.wr(5'h01, 8'h00);
    pmicia_host_i.wr(5'h1C, 8'h00);
    @(posedge SYS_CLK) EVENT_PULSE <= {8'h01, {8{8'h00}}, 8'h01};
    @(posedge SYS_CLK) EVENT_PULSE <= '0;
    pmicia_host_i.wr(5'h00, 8'h01);
    rdc(sum_a, 8'h40);
    chk({6'h00, IRQ_REQUEST_PIN_OE, IRQ_REQUEST_PIN_N}, 8'h02);
    pmicia_host_i.wr(5'h1B, 8'h01);
    rdc(sum_a, 8'h00);
    chk({6'h00, IRQ_REQUEST_PIN_OE, IRQ_REQUEST_PIN_N}, 8'h01);
    $display("done two groups");
    @(posedge SYS_CLK) EARLY_WARNING_EVENT <= 1'b1;
    @(posedge SYS_CLK) EARLY_WARNING_EVENT <= 1'b0;
    rdc(sum_a, 8'h80);
    chk({6'h00, IRQ_REQUEST_PIN_OE, IRQ_REQUEST_PIN_N}, 8'h02);
    pmicia_host_i.wr(sum_a, 8'h80);
    rdc(sum_a, 8'h00);
    rdc(5'h1F, 8'h00);
    $display("done warning and unmapped");
    finish_test();
  end
endmodule // tb
`default_nettype wire
